// File: spi_host_model.sv
// host side of the serial register port, mode 0, 320 ns bit time
`timescale 1ns/10ps
module spi_host_model (
    input wire logic sys_clk,
    input wire logic spi_sdo,
    output logic spi_sclk,
    output logic spi_csn,
    output logic spi_sdi
);
    logic [7:0] rbuf [0:15];
    initial begin
        spi_csn = 1'b1;
        spi_sclk = 1'b0;
        spi_sdi = 1'b0;
    end
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            spi_sdi <= tx[i];
            repeat (4) @(posedge sys_clk);
            spi_sclk <= 1'b1;
            repeat (3) @(posedge sys_clk);
            @(negedge sys_clk);
            rx[i] = spi_sdo;
            @(posedge sys_clk);
            spi_sclk <= 1'b0;
        end
    endtask
    task automatic frame(input logic [7:0] hdr, input int n, input logic [7:0] wd);
        logic [7:0] rx;
        @(posedge sys_clk);
        spi_csn <= 1'b0;
        repeat (4) @(posedge sys_clk);
        xfer(hdr, rx);
        for (int j = 0; j < n; j++) begin
            xfer(wd, rbuf[j]);
        end
        repeat (4) @(posedge sys_clk);
        spi_csn <= 1'b1;
        spi_sdi <= ~spi_sdi;
        repeat (8) @(posedge sys_clk);
    endtask
endmodule

// File: tb_touch_sequence_monitor_control.sv
// self-checking bench for the touch sequence block
`timescale 1ns/10ps
`define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin num_errors++; $display("mismatch %s expected %h seen %h", nm, e, s); end end
module tb_touch_sequence_monitor_control;
    import touch_seq_pkg::*;
    logic sys_clk, rst, touch_detect, spi_sclk, spi_csn, spi_sdi, spi_sdo;
    logic pen_irq_n_out, pen_irq_oe, osc_power_on, analog_power_on, busy_seen;
    conv_req_t conv_req;
    conv_result_t conv_result;
    int num_errors = 0;
    int n_checks = 0;
    int cycles = 0;
    int k = 0;
    logic [2:0] last_ch = 3'h7;
    logic [11:0] base [0:4] = '{12'h5a3, 12'h3c1, 12'h7e9, 12'h214, 12'h9b6};
    touch_sequence_monitor_control DUT (.sys_clk(sys_clk), .rst(rst), .spi_sclk(spi_sclk), .spi_csn(spi_csn),
        .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .touch_detect(touch_detect), .pen_irq_n_out(pen_irq_n_out),
        .pen_irq_oe(pen_irq_oe), .osc_power_on(osc_power_on), .analog_power_on(analog_power_on),
        .conv_req(conv_req), .conv_result(conv_result));
    spi_host_model host (.sys_clk(sys_clk), .spi_sdo(spi_sdo), .spi_sclk(spi_sclk), .spi_csn(spi_csn),
        .spi_sdi(spi_sdi));
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    // --------
    // converter stand-in: lowest, highest, then channel value
    // --------
    always @(posedge sys_clk) begin
        conv_result.valid <= conv_req.start;
        if (conv_req.start === 1'b1) begin
            k = (conv_req.channel == last_ch) ? k + 1 : 0;
            last_ch = conv_req.channel;
            conv_result.data <= (k == 0) ? 12'h000 : (k == 1) ? 12'hfff : base[conv_req.channel];
        end
        if (!pen_irq_n_out && analog_power_on) busy_seen <= 1'b1;
        cycles++;
        if (cycles == 60000) begin
            num_errors++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic run_seq(input logic [7:0] ctrl);
        int t;
        busy_seen = 1'b0;
        host.frame(8'h02, 1, ctrl);
        t = 0;
        while (pen_irq_n_out !== 1'b1 && t < 2000) begin
            @(negedge sys_clk);
            t++;
        end
        `CHK("busy_seen", 1'b1, busy_seen)
        `CHK("pen_done", 1'b1, pen_irq_n_out)
        repeat (520) @(negedge sys_clk);
        `CHK("osc_off", 1'b0, osc_power_on)
    endtask
    task automatic chk_cal(input logic [11:0] x, input logic [11:0] y);
        host.frame(8'ha0, 4, 8'h00);
        `CHK("x_high", x[11:4], host.rbuf[0])
        `CHK("x_low", {x[3:0], 4'h0}, host.rbuf[1])
        `CHK("y_high", y[11:4], host.rbuf[2])
        `CHK("y_low", {y[3:0], 4'h0}, host.rbuf[3])
    endtask
    initial begin
        rst = 1'b1;
        touch_detect = 1'b0;
        busy_seen = 1'b0;
        conv_result = '0;
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (6) @(posedge sys_clk);
        host.frame(8'h00, 1, 8'h00);
        host.frame(8'h99, 12, 8'h00);
        for (int i = 0; i < 12; i++) `CHK("reset_map", (i == 7 || i == 9) ? 8'h80 : 8'h00, host.rbuf[i])
        host.frame(8'h20, 1, 8'h12);
        host.frame(8'h23, 1, 8'hf0);
        chk_cal(12'h120, 12'h80f);
        host.frame(8'h0c, 1, 8'h40);
        run_seq(8'h90);
        chk_cal(12'h120, 12'h80f);
        host.frame(8'h0c, 1, 8'hc0);
        run_seq(8'h80);
        chk_cal(base[0], base[1]);
        @(posedge sys_clk);
        touch_detect <= 1'b1;
        host.frame(8'h03, 1, 8'h01);
        run_seq(8'ha2);
        host.frame(8'h90, 11, 8'h00);
        `CHK("status", 8'h42, host.rbuf[0])
        for (int i = 0; i < 4; i++) begin
            `CHK("data_high", base[i][11:4], host.rbuf[2 * i + 1])
            `CHK("data_low", {base[i][3:0], 4'h0}, host.rbuf[2 * i + 2])
        end
        `CHK("press_high", {2'b00, base[4][11:6]}, host.rbuf[9])
        `CHK("press_low", {base[4][5:2], 4'h0}, host.rbuf[10])
        host.frame(8'ha4, 1, 8'h00);
        `CHK("monitor", base[2][11:4], host.rbuf[0])
        host.frame(8'h90, 2, 8'h00);
        `CHK("dval_clear", 2'b00, host.rbuf[0][1:0])
        `CHK("data_clear", 8'h00, host.rbuf[1])
        host.frame(8'h00, 1, 8'h00);
        chk_cal(12'h800, 12'h800);
        for (int s = 0; s < 3; s++) begin
            host.frame(8'h03, 1, 8'(s << 4));
            repeat (10) @(negedge sys_clk);
            if (s != 2) `CHK("pen_sleep", (s != 0), pen_irq_n_out)
            `CHK("oe_sleep", (s != 2), pen_irq_oe)
        end
        complete_run();
    end
endmodule

// File: touch_seq_pkg.sv
// constants, types and register map of the touch sequence monitor and control block
package touch_seq_pkg;
    // ----------------------------------------
    // clock and timing
    // ----------------------------------------
    localparam int CLK_HZ = 25_000_000;
    localparam int OSC_OFF_DELAY_NS = 20_000;
    localparam int OSC_OFF_CYCLES_INT = (OSC_OFF_DELAY_NS * (CLK_HZ / 1_000_000)) / 1000;
    localparam logic [8:0] OSC_OFF_CYCLES = 9'(OSC_OFF_CYCLES_INT);

    // ----------------------------------------
    // register addresses
    // ----------------------------------------
    localparam logic [6:0] ADDR_SYS_RESET = 7'h00;
    localparam logic [6:0] ADDR_SEQ_CTRL = 7'h02;
    localparam logic [6:0] ADDR_FILTER = 7'h03;
    localparam logic [6:0] ADDR_CAL_CTRL = 7'h0c;
    localparam logic [6:0] ADDR_STATUS = 7'h10;
    localparam logic [6:0] ADDR_DATA_FIRST = 7'h11;
    localparam logic [6:0] ADDR_DATA_LAST = 7'h18;
    localparam logic [6:0] ADDR_PRESS_HIGH = 7'h19;
    localparam logic [6:0] ADDR_PRESS_LOW = 7'h1a;
    localparam logic [6:0] ADDR_X_INIT_HIGH = 7'h20;
    localparam logic [6:0] ADDR_X_INIT_LOW = 7'h21;
    localparam logic [6:0] ADDR_Y_INIT_HIGH = 7'h22;
    localparam logic [6:0] ADDR_Y_INIT_LOW = 7'h23;
    localparam logic [6:0] ADDR_MONITOR = 7'h24;

    // ----------------------------------------
    // field positions and reset values
    // ----------------------------------------
    localparam int HDR_READ_BIT = 7;
    localparam int SEQ_MODE_LSB = 4;
    localparam int INTERVAL_LSB = 0;
    localparam int FILTER_LSB = 0;
    localparam int SLEEP_LSB = 4;
    localparam int CAL_UPDATE_BIT = 7;
    localparam int STAT_TOUCH_BIT = 6;
    localparam int STAT_DVAL_BIT = 1;
    localparam int STAT_BUSY_BIT = 0;
    localparam logic [7:0] SEQ_CTRL_RESET = 8'h00;
    localparam logic [7:0] FILTER_RESET = 8'h00;
    localparam logic [7:0] CAL_CTRL_RESET = 8'hc0;
    localparam logic [11:0] INIT_CAL_RESET = 12'h800;
    localparam logic [2:0] FILTER_MAX_SHIFT = 3'h4;

    // ----------------------------------------
    // sequence mode codes and sleep codes
    // ----------------------------------------
    localparam logic [3:0] MODE_DUAL_INIT = 4'h8;
    localparam logic [3:0] MODE_DUAL_CAL = 4'h9;
    localparam logic [3:0] MODE_DUAL_TOUCH = 4'ha;
    localparam logic [1:0] SLEEP_NORMAL = 2'h0;
    localparam logic [1:0] SLEEP_HIGH = 2'h1;
    localparam logic [1:0] SLEEP_FLOAT = 2'h2;

    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_CONV = 4'b0010,
        ST_AVG = 4'b0100,
        ST_HOLD = 4'b1000
    } seq_state_t;

    typedef struct packed {
        logic start;
        logic [2:0] channel;
    } conv_req_t;

    typedef struct packed {
        logic valid;
        logic [11:0] data;
    } conv_result_t;
endpackage

// File: touch_seq_sva.sv
// assertion checker for the touch sequence block ports
`timescale 1ns/10ps
module touch_seq_sva (
    input logic sys_clk,
    input logic rst,
    input logic spi_csn,
    input logic spi_sdo,
    input logic pen_irq_n_out,
    input logic pen_irq_oe,
    input logic osc_power_on,
    input logic analog_power_on,
    input touch_seq_pkg::conv_req_t conv_req
);
    import touch_seq_pkg::*;
    // --------
    // hold-phase cycle count
    // --------
    logic [9:0] hold_cnt;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            hold_cnt <= 10'h000;
        end else if (osc_power_on && pen_irq_n_out && !analog_power_on) begin
            hold_cnt <= hold_cnt + 10'h001;
        end else begin
            hold_cnt <= 10'h000;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence busy_s;
        !pen_irq_n_out && pen_irq_oe && osc_power_on;
    endsequence
    sequence done_s;
        $rose(pen_irq_n_out) && osc_power_on;
    endsequence
    busy_pen_low_a: assert property (analog_power_on |-> busy_s) else $error("pen not busy");
    done_power_a: assert property (done_s |-> !analog_power_on ##1 osc_power_on [*8]) else $error("early off");
    osc_hold_max_a: assert property (hold_cnt <= 10'd502) else $error("osc stays on");
    osc_off_time_a: assert property ($fell(osc_power_on) |-> hold_cnt >= 10'd497) else $error("osc off early");
    req_active_a: assert property (conv_req.start |=> analog_power_on) else $error("req unpowered");
    sdo_idle_a: assert property (spi_csn && $past(spi_csn, 4) |-> !spi_sdo) else $error("sdo idle");
    float_down_a: assert property (!pen_irq_oe |-> !osc_power_on && !analog_power_on) else $error("float");
    reset_state_a: assert property ($fell(rst) |-> pen_irq_n_out && !osc_power_on) else $error("reset");
endmodule
bind touch_sequence_monitor_control touch_seq_sva chk (.sys_clk(sys_clk), .rst(rst), .spi_csn(spi_csn),
    .spi_sdo(spi_sdo), .pen_irq_n_out(pen_irq_n_out), .pen_irq_oe(pen_irq_oe), .osc_power_on(osc_power_on),
    .analog_power_on(analog_power_on), .conv_req(conv_req));

// File: touch_sequence_monitor_control.sv
// sequence control, result registers and serial register port of the touch controller
`timescale 1ns/10ps
module touch_sequence_monitor_control (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic spi_sclk,
    input wire logic spi_csn,
    input wire logic spi_sdi,
    output logic spi_sdo,
    input wire logic touch_detect,
    output logic pen_irq_n_out,
    output logic pen_irq_oe,
    output logic osc_power_on,
    output logic analog_power_on,
    output touch_seq_pkg::conv_req_t conv_req,
    input touch_seq_pkg::conv_result_t conv_result
);
    import touch_seq_pkg::*;
    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [3:0] sync1_reg;
    logic [3:0] sync2_reg;
    logic sclk_prev_reg, csn_prev_reg, sclk_s, csn_s, sdi_s, touch_s;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sync1_reg <= 4'h2;
            sync2_reg <= 4'h2;
            sclk_prev_reg <= 1'b0;
            csn_prev_reg <= 1'b1;
        end else begin
            sync1_reg <= {touch_detect, spi_sdi, spi_csn, spi_sclk};
            sync2_reg <= sync1_reg;
            sclk_prev_reg <= sync2_reg[0];
            csn_prev_reg <= sync2_reg[1];
        end
    end
    assign sclk_s = sync2_reg[0];
    assign csn_s = sync2_reg[1];
    assign sdi_s = sync2_reg[2];
    assign touch_s = sync2_reg[3];
    // ----------------------------------------
    // serial framing
    // ----------------------------------------
    logic [2:0] bit_cnt_reg;
    logic [7:0] rx_shift_reg, tx_shift_reg, rx_next, rd_data;
    logic [6:0] addr_reg, load_addr;
    logic first_byte_reg, read_mode_reg, sclk_rise, sclk_fall, csn_rise, byte_done, hdr_done, wr_en, load_tx;
    assign sclk_rise = sclk_s & ~sclk_prev_reg;
    assign sclk_fall = ~sclk_s & sclk_prev_reg;
    assign csn_rise = csn_s & ~csn_prev_reg;
    assign rx_next = {rx_shift_reg[6:0], sdi_s};
    assign byte_done = ~csn_s & sclk_rise & (bit_cnt_reg == 3'h7);
    assign hdr_done = byte_done & first_byte_reg;
    assign wr_en = byte_done & ~first_byte_reg & ~read_mode_reg;
    assign load_tx = byte_done & (first_byte_reg ? rx_next[HDR_READ_BIT] : read_mode_reg);
    assign load_addr = first_byte_reg ? rx_next[6:0] : addr_reg;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            bit_cnt_reg <= 3'h0;
            rx_shift_reg <= 8'h00;
            first_byte_reg <= 1'b1;
            read_mode_reg <= 1'b0;
            addr_reg <= 7'h00;
        end else if (csn_s) begin
            bit_cnt_reg <= 3'h0;
            first_byte_reg <= 1'b1;
            read_mode_reg <= 1'b0;
        end else if (sclk_rise) begin
            rx_shift_reg <= rx_next;
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (hdr_done) begin
                first_byte_reg <= 1'b0;
                read_mode_reg <= rx_next[HDR_READ_BIT];
                addr_reg <= rx_next[HDR_READ_BIT] ? rx_next[6:0] + 7'h01 : rx_next[6:0];
            end else if (byte_done) begin
                addr_reg <= addr_reg + 7'h01;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tx_shift_reg <= 8'h00;
            spi_sdo <= 1'b0;
        end else begin
            if (load_tx) begin
                tx_shift_reg <= rd_data;
            end else if (sclk_fall & read_mode_reg & ~csn_s & (bit_cnt_reg != 3'h0)) begin
                tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
            end
            spi_sdo <= read_mode_reg & ~csn_s & tx_shift_reg[7];
        end
    end
    // ----------------------------------------
    // control registers
    // ----------------------------------------
    logic [7:0] seq_ctrl_reg, filter_reg, cal_ctrl_reg;
    logic soft_reset, seq_start;
    seq_state_t state_reg;
    assign soft_reset = wr_en & (addr_reg == ADDR_SYS_RESET);
    assign seq_start = wr_en & (addr_reg == ADDR_SEQ_CTRL) & (state_reg == ST_IDLE || state_reg == ST_HOLD);
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            seq_ctrl_reg <= SEQ_CTRL_RESET;
            filter_reg <= FILTER_RESET;
            cal_ctrl_reg <= CAL_CTRL_RESET;
        end else if (soft_reset) begin
            seq_ctrl_reg <= SEQ_CTRL_RESET;
            filter_reg <= FILTER_RESET;
            cal_ctrl_reg <= CAL_CTRL_RESET;
        end else if (wr_en) begin
            case (addr_reg)
                ADDR_SEQ_CTRL: seq_ctrl_reg <= rx_next;
                ADDR_FILTER: filter_reg <= rx_next;
                ADDR_CAL_CTRL: cal_ctrl_reg <= rx_next;
                default: ;
            endcase
        end
    end
    // ----------------------------------------
    // sequence engine
    // ----------------------------------------
    logic [3:0] run_mode_reg;
    logic [2:0] chan_reg, shift;
    logic [4:0] samp_cnt_reg;
    logic [16:0] sum_reg, trimmed;
    logic [11:0] min_reg, max_reg, avg;
    logic [8:0] timer_reg;
    function automatic logic [2:0] filter_shift(input logic [2:0] code);
        filter_shift = (code > FILTER_MAX_SHIFT) ? FILTER_MAX_SHIFT : code;
    endfunction
    function automatic logic [4:0] sample_count(input logic [2:0] sh);
        sample_count = 5'((5'h01 << sh) + 5'h02);
    endfunction
    function automatic logic [2:0] channel_count(input logic [3:0] mode);
        if (mode == MODE_DUAL_INIT || mode == MODE_DUAL_CAL) begin
            channel_count = 3'h2;
        end else if (mode == MODE_DUAL_TOUCH) begin
            channel_count = 3'h5;
        end else begin
            channel_count = 3'h4;
        end
    endfunction
    assign shift = filter_shift(filter_reg[FILTER_LSB +: 3]);
    assign trimmed = sum_reg - {5'h00, min_reg} - {5'h00, max_reg};
    assign avg = 12'(trimmed >> shift);
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            run_mode_reg <= 4'h0;
            chan_reg <= 3'h0;
            samp_cnt_reg <= 5'h00;
            sum_reg <= 17'h00000;
            min_reg <= 12'hfff;
            max_reg <= 12'h000;
            timer_reg <= 9'h000;
            conv_req <= '0;
        end else if (soft_reset) begin
            state_reg <= ST_IDLE;
            conv_req <= '0;
        end else begin
            conv_req.start <= 1'b0;
            case (state_reg)
                ST_IDLE, ST_HOLD: begin
                    timer_reg <= timer_reg + 9'h001;
                    if (state_reg == ST_HOLD && timer_reg == OSC_OFF_CYCLES - 9'h001) begin
                        state_reg <= ST_IDLE;
                    end
                    if (seq_start) begin
                        state_reg <= ST_CONV;
                        run_mode_reg <= rx_next[SEQ_MODE_LSB +: 4];
                        chan_reg <= 3'h0;
                        samp_cnt_reg <= 5'h00;
                        sum_reg <= 17'h00000;
                        min_reg <= 12'hfff;
                        max_reg <= 12'h000;
                        conv_req <= '{start: 1'b1, channel: 3'h0};
                    end
                end
                ST_CONV: begin
                    if (conv_result.valid) begin
                        sum_reg <= sum_reg + {5'h00, conv_result.data};
                        if (conv_result.data < min_reg) min_reg <= conv_result.data;
                        if (conv_result.data > max_reg) max_reg <= conv_result.data;
                        samp_cnt_reg <= samp_cnt_reg + 5'h01;
                        if (samp_cnt_reg + 5'h01 == sample_count(shift)) begin
                            state_reg <= ST_AVG;
                        end else begin
                            conv_req <= '{start: 1'b1, channel: chan_reg};
                        end
                    end
                end
                ST_AVG: begin
                    if (chan_reg + 3'h1 == channel_count(run_mode_reg)) begin
                        state_reg <= ST_HOLD;
                        timer_reg <= 9'h000;
                    end else begin
                        state_reg <= ST_CONV;
                        chan_reg <= chan_reg + 3'h1;
                        samp_cnt_reg <= 5'h00;
                        sum_reg <= 17'h00000;
                        min_reg <= 12'hfff;
                        max_reg <= 12'h000;
                        conv_req <= '{start: 1'b1, channel: chan_reg + 3'h1};
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end
    // ----------------------------------------
    // result and calibration registers
    // ----------------------------------------
    logic [11:0] data_reg [4];
    logic [9:0] pressure_reg;
    logic [7:0] monitor_reg;
    logic [11:0] x_init_reg, y_init_reg;
    logic dval_reg, touch_at_start_reg, clear_pend_reg, store_en, is_init_mode, init_allowed, last_read, seq_done;
    assign store_en = (state_reg == ST_AVG);
    assign seq_done = store_en & (chan_reg + 3'h1 == channel_count(run_mode_reg));
    assign is_init_mode = (run_mode_reg == MODE_DUAL_INIT) || (run_mode_reg == MODE_DUAL_CAL);
    assign init_allowed = (run_mode_reg == MODE_DUAL_INIT) || cal_ctrl_reg[CAL_UPDATE_BIT];
    assign last_read = load_tx & (load_addr == ((run_mode_reg == MODE_DUAL_TOUCH) ? ADDR_PRESS_LOW : ADDR_DATA_LAST));
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 4; i++) data_reg[i] <= 12'h000;
            pressure_reg <= 10'h000;
            monitor_reg <= 8'h00;
            x_init_reg <= INIT_CAL_RESET;
            y_init_reg <= INIT_CAL_RESET;
            dval_reg <= 1'b0;
            touch_at_start_reg <= 1'b0;
            clear_pend_reg <= 1'b0;
        end else if (soft_reset) begin
            for (int i = 0; i < 4; i++) data_reg[i] <= 12'h000;
            pressure_reg <= 10'h000;
            monitor_reg <= 8'h00;
            x_init_reg <= INIT_CAL_RESET;
            y_init_reg <= INIT_CAL_RESET;
            dval_reg <= 1'b0;
            clear_pend_reg <= 1'b0;
        end else begin
            if (last_read) clear_pend_reg <= 1'b1;
            if (csn_rise && clear_pend_reg) begin
                for (int i = 0; i < 4; i++) data_reg[i] <= 12'h000;
                pressure_reg <= 10'h000;
                dval_reg <= 1'b0;
                clear_pend_reg <= 1'b0;
            end
            if (seq_start) begin
                dval_reg <= 1'b0;
                touch_at_start_reg <= touch_s;
            end
            if (wr_en) begin
                case (addr_reg)
                    ADDR_X_INIT_HIGH: x_init_reg[11:4] <= rx_next;
                    ADDR_X_INIT_LOW: x_init_reg[3:0] <= rx_next[7:4];
                    ADDR_Y_INIT_HIGH: y_init_reg[11:4] <= rx_next;
                    ADDR_Y_INIT_LOW: y_init_reg[3:0] <= rx_next[7:4];
                    default: ;
                endcase
            end
            if (store_en && is_init_mode && init_allowed) begin
                if (chan_reg == 3'h0) x_init_reg <= avg;
                else y_init_reg <= avg;
            end else if (store_en && !is_init_mode) begin
                if (chan_reg == 3'h4) pressure_reg <= avg[11:2];
                else data_reg[chan_reg[1:0]] <= avg;
                if (run_mode_reg == MODE_DUAL_TOUCH && chan_reg == 3'h2) monitor_reg <= avg[11:4];
            end
            if (seq_done) dval_reg <= 1'b1;
        end
    end

    // ----------------------------------------
    // register read mux
    // ----------------------------------------
    always_comb begin
        rd_data = 8'h00;
        case (load_addr)
            ADDR_SEQ_CTRL: rd_data = seq_ctrl_reg;
            ADDR_FILTER: rd_data = filter_reg;
            ADDR_CAL_CTRL: rd_data = cal_ctrl_reg;
            ADDR_STATUS: begin
                rd_data[STAT_TOUCH_BIT] = touch_at_start_reg;
                rd_data[STAT_DVAL_BIT] = dval_reg;
                rd_data[STAT_BUSY_BIT] = (state_reg == ST_CONV) || (state_reg == ST_AVG);
            end
            ADDR_PRESS_HIGH: rd_data = {2'h0, pressure_reg[9:4]};
            ADDR_PRESS_LOW: rd_data = {pressure_reg[3:0], 4'h0};
            ADDR_X_INIT_HIGH: rd_data = x_init_reg[11:4];
            ADDR_X_INIT_LOW: rd_data = {x_init_reg[3:0], 4'h0};
            ADDR_Y_INIT_HIGH: rd_data = y_init_reg[11:4];
            ADDR_Y_INIT_LOW: rd_data = {y_init_reg[3:0], 4'h0};
            ADDR_MONITOR: rd_data = monitor_reg;
            default: begin
                if (load_addr >= ADDR_DATA_FIRST && load_addr <= ADDR_DATA_LAST) begin
                    if (load_addr[0]) rd_data = data_reg[2'(3'(load_addr - ADDR_DATA_FIRST) >> 1)][11:4];
                    else rd_data = {data_reg[2'(3'(load_addr - ADDR_DATA_FIRST) >> 1)][3:0], 4'h0};
                end
            end
        endcase
    end

    // ----------------------------------------
    // pen pin and power control
    // ----------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pen_irq_n_out <= 1'b1;
            pen_irq_oe <= 1'b1;
            osc_power_on <= 1'b0;
            analog_power_on <= 1'b0;
        end else begin
            osc_power_on <= (state_reg != ST_IDLE);
            analog_power_on <= (state_reg == ST_CONV) || (state_reg == ST_AVG);
            if (state_reg == ST_CONV || state_reg == ST_AVG) begin
                pen_irq_n_out <= 1'b0;
                pen_irq_oe <= 1'b1;
            end else if (state_reg == ST_HOLD) begin
                pen_irq_n_out <= 1'b1;
                pen_irq_oe <= 1'b1;
            end else begin
                case (filter_reg[SLEEP_LSB +: 2])
                    SLEEP_NORMAL: begin
                        pen_irq_n_out <= ~touch_s;
                        pen_irq_oe <= 1'b1;
                    end
                    SLEEP_FLOAT: begin
                        pen_irq_n_out <= 1'b1;
                        pen_irq_oe <= 1'b0;
                    end
                    default: begin
                        pen_irq_n_out <= 1'b1;
                        pen_irq_oe <= 1'b1;
                    end
                endcase
            end
        end
    end
endmodule
